// ---- inc/cepu_pkg.sv ----
// Package of constants and carrier types for the exception priority unit.
package cepu_pkg;

    // Priority ranks, lowest number wins.
    localparam logic [3:0] RANK_RESET     = 4'h0;
    localparam logic [3:0] RANK_SMI       = 4'h1;
    localparam logic [3:0] RANK_DBG_PREV  = 4'h2;
    localparam logic [3:0] RANK_DBG_NEXT  = 4'h3;
    localparam logic [3:0] RANK_NMI       = 4'h4;
    localparam logic [3:0] RANK_MIRQ      = 4'h5;
    localparam logic [3:0] RANK_FETCH     = 4'h6;
    localparam logic [3:0] RANK_DECODE    = 4'h7;
    localparam logic [3:0] RANK_WAIT_DNA  = 4'h8;
    localparam logic [3:0] RANK_FOP_DNA   = 4'h9;
    localparam logic [3:0] RANK_FPU_ERR   = 4'hA;
    localparam logic [3:0] RANK_SEG_OPND  = 4'hB;
    localparam logic [3:0] RANK_PAGE_OPND = 4'hC;
    localparam logic [3:0] RANK_ALIGN     = 4'hD;
    localparam logic [3:0] RANK_NONE      = 4'hF;
    localparam int         NUM_SRC        = 14;

    // Vector numbers.
    localparam logic [7:0] VEC_DEBUG      = 8'h01;
    localparam logic [7:0] VEC_NMI        = 8'h02;
    localparam logic [7:0] VEC_BREAK      = 8'h03;
    localparam logic [7:0] VEC_BAD_OPCODE = 8'h06;
    localparam logic [7:0] VEC_DEV_NA     = 8'h07;
    localparam logic [7:0] VEC_DOUBLE     = 8'h08;
    localparam logic [7:0] VEC_BAD_TASK   = 8'h0A;
    localparam logic [7:0] VEC_SEG_NP     = 8'h0B;
    localparam logic [7:0] VEC_STACK      = 8'h0C;
    localparam logic [7:0] VEC_GEN_PROT   = 8'h0D;
    localparam logic [7:0] VEC_PAGE       = 8'h0E;
    localparam logic [7:0] VEC_FPU_ERR    = 8'h10;
    localparam logic [7:0] VEC_ALIGN      = 8'h11;

    // Error code fields.
    localparam int         EC_SEL_LSB     = 3;
    localparam int         EC_S2_BIT      = 2;
    localparam int         EC_S1_BIT      = 1;
    localparam int         EC_S0_BIT      = 0;
    localparam logic [15:0] EC_ZERO       = 16'h0000;

    // Register block, classic Wishbone, byte addresses.
    localparam logic [3:0] ADDR_CTRL      = 4'h0;
    localparam logic [3:0] ADDR_STATUS    = 4'h4;
    localparam logic [3:0] ADDR_RESULT    = 4'h8;
    localparam int         CTRL_PROT_BIT  = 0;
    localparam int         CTRL_IF_BIT    = 1;
    localparam int         CTRL_TSW_BIT   = 2;
    localparam int         CTRL_MON_BIT   = 3;
    localparam int         CTRL_EMU_BIT   = 4;
    localparam int         CTRL_NERR_BIT  = 5;
    localparam int         CTRL_NMI_EN_BIT = 6;
    localparam logic [6:0] CTRL_RESET     = 7'h00;

    // Fault kind for fetch and operand segment faults.
    typedef enum logic [1:0] {
        CEPU_SEG_NOT_PRESENT,
        CEPU_SEG_STACK,
        CEPU_SEG_GEN_PROT,
        CEPU_SEG_TASK_STATE
    } cepu_seg_kind_t;

    // Faults and events offered by the pipeline at a boundary.
    typedef struct packed {
        logic           dbg_prev;
        logic           dbg_next;
        logic           fetch_fault;
        logic           fetch_page;
        cepu_seg_kind_t fetch_kind;
        logic           decode_fault;
        logic           is_wait;
        logic           is_float_unit_opcode;
        logic           fpu_unmasked_err;
        logic           opnd_seg_fault;
        cepu_seg_kind_t opnd_kind;
        logic           opnd_page_fault;
        logic           page_not_present;
        logic           page_write;
        logic           page_user;
        logic           align_fault;
        logic           double_fault;
        logic [12:0]    sel_index;
        logic           sel_ti;
        logic           sel_ext;
    } cepu_events_t;

    // Dispatch result.
    typedef struct packed {
        logic           valid;
        logic           mgmt_entry;
        logic [3:0]     rank;
        logic [7:0]     vector;
        logic           push_error;
        logic [15:0]    error_code;
        logic           restartable;
        logic           real_mode_meaning;
    } cepu_dispatch_t;

endpackage

// ---- verilog/cepu_resolver.sv ----
// Exception and interrupt priority resolver with a Wishbone register block.
`timescale 1ns/1ps

// Notes on behaviour
// - Reset outranks everything and clears all pending events.
// - System management request ranks first after reset.
// - Debug events of previous instruction rank below system management.
// - Execution breakpoints of next instruction rank below those, above NMI.
// - NMI wins over maskable request at the same boundary.
// - Maskable request is taken only with interrupt enable set.
// - Fetch faults rank below the maskable request.
// - Decode faults rank directly below fetch faults.
// - Wait raises device-not-available when task switched and monitor flags set.
// - Float opcode raises device-not-available on emulation or task switched.
// - Float error raised for unmasked error only with numeric error flag.
// - Lowest ranks: operand segment faults, operand page faults, alignment.
// - Only one exception is generated per attempt at an instruction.
// - Faults are restartable except a switch into a partly absent task segment and a double fault.
// - Real mode never raises invalid task, not present or page fault.
// - Real mode vector 8 means interrupt table limit overrun.
// - Real mode vector 12 means stack segment limit overrun.
// - Vector 13 pushes an error code only in protected mode.
// - Protected mode pushes 16-bit codes for the seven listed exceptions.
// - Page fault error code selector field is meaningless.
// - Double fault and alignment check push a zero error code.
// - Page fault code bit 1 is zero for reads, one for writes.
// - NMI dispatches through vector 2.
module cepu_resolver (
    // Clock and reset.
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    clk_en,
    // External requests.
    input  wire logic                    system_mgmt_irq_n,
    input  wire logic                    nmi_request,
    input  wire logic                    maskable_irq_request,
    // Pipeline side.
    input  wire logic                    boundary,
    input  wire cepu_pkg::cepu_events_t  events,
    input  wire logic                    task_switch_partial,
    output logic                         sys_mgmt_mode,
    output cepu_pkg::cepu_dispatch_t     dispatch,
    // Wishbone slave.
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [3:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o
);

    logic [6:0]                ctrl;
    logic                      smi_prev;
    logic                      smi_pend;
    logic                      nmi_pend;
    logic                      nmi_prev;
    logic [cepu_pkg::NUM_SRC-1:0] req;
    logic [3:0]                next_rank;
    cepu_pkg::cepu_dispatch_t  next_dispatch;
    logic                      prot;
    logic                      wb_hit;

    assign prot   = ctrl[cepu_pkg::CTRL_PROT_BIT];
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Picks the lowest set index; used for both the winner and the status view.
    function automatic logic [3:0] first_set(input logic [cepu_pkg::NUM_SRC-1:0] v);
        logic [3:0] r;
        r = cepu_pkg::RANK_NONE;
        for (int i = cepu_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Maps a segment fault kind to its vector, honouring real mode.
    function automatic logic [7:0] seg_vector(input cepu_pkg::cepu_seg_kind_t k);
        logic [7:0] v;
        unique case (k)
            cepu_pkg::CEPU_SEG_NOT_PRESENT: v = cepu_pkg::VEC_SEG_NP;
            cepu_pkg::CEPU_SEG_STACK:       v = cepu_pkg::VEC_STACK;
            cepu_pkg::CEPU_SEG_GEN_PROT:    v = cepu_pkg::VEC_GEN_PROT;
            cepu_pkg::CEPU_SEG_TASK_STATE:  v = cepu_pkg::VEC_BAD_TASK;
        endcase
        // Absent segments and task state faults fall back to a limit overrun in real mode.
        if (!prot && (v == cepu_pkg::VEC_SEG_NP || v == cepu_pkg::VEC_BAD_TASK)) begin
            v = cepu_pkg::VEC_GEN_PROT;
        end
        return v;
    endfunction

    // Selector-style error code for segment faults.
    function automatic logic [15:0] seg_code(input cepu_pkg::cepu_events_t e);
        logic [15:0] c;
        c = {e.sel_index, 3'h0};
        c[cepu_pkg::EC_S2_BIT] = e.sel_ti;
        c[cepu_pkg::EC_S0_BIT] = e.sel_ext;
        return c;
    endfunction

    // Request vector in rank order.
    always_comb begin
        req = '0;
        req[cepu_pkg::RANK_SMI]   = smi_pend;
        req[cepu_pkg::RANK_DBG_PREV] = events.dbg_prev;
        req[cepu_pkg::RANK_DBG_NEXT] = events.dbg_next;
        req[cepu_pkg::RANK_NMI]   = nmi_pend && ctrl[cepu_pkg::CTRL_NMI_EN_BIT];
        req[cepu_pkg::RANK_MIRQ]  = maskable_irq_request && ctrl[cepu_pkg::CTRL_IF_BIT];
        req[cepu_pkg::RANK_FETCH] = events.fetch_fault || (events.fetch_page && prot);
        req[cepu_pkg::RANK_DECODE] = events.decode_fault;
        req[cepu_pkg::RANK_WAIT_DNA] = events.is_wait && ctrl[cepu_pkg::CTRL_TSW_BIT]
                                     && ctrl[cepu_pkg::CTRL_MON_BIT];
        req[cepu_pkg::RANK_FOP_DNA] = events.is_float_unit_opcode
                                    && (ctrl[cepu_pkg::CTRL_EMU_BIT] || ctrl[cepu_pkg::CTRL_TSW_BIT]);
        req[cepu_pkg::RANK_FPU_ERR] = events.fpu_unmasked_err && ctrl[cepu_pkg::CTRL_NERR_BIT];
        req[cepu_pkg::RANK_SEG_OPND] = events.opnd_seg_fault;
        req[cepu_pkg::RANK_PAGE_OPND] = events.opnd_page_fault && prot;
        req[cepu_pkg::RANK_ALIGN] = events.align_fault || events.double_fault;
    end

    // Only one winner is chosen per boundary.
    assign next_rank = first_set(req);

    always_comb begin
        next_dispatch = '0;
        next_dispatch.valid = boundary && (next_rank != cepu_pkg::RANK_NONE);
        next_dispatch.rank = next_rank;
        next_dispatch.restartable = 1'b1;
        unique case (next_rank)
            cepu_pkg::RANK_SMI: begin
                next_dispatch.mgmt_entry = 1'b1;
            end
            cepu_pkg::RANK_DBG_PREV, cepu_pkg::RANK_DBG_NEXT: begin
                next_dispatch.vector = cepu_pkg::VEC_DEBUG;
            end
            cepu_pkg::RANK_NMI: begin
                next_dispatch.vector = cepu_pkg::VEC_NMI;
            end
            cepu_pkg::RANK_MIRQ: begin
                // The external controller supplies the vector in its acknowledge cycle.
                next_dispatch.vector = 8'h00;
            end
            cepu_pkg::RANK_FETCH, cepu_pkg::RANK_SEG_OPND: begin
                if (next_rank == cepu_pkg::RANK_FETCH && !events.fetch_fault) begin
                    next_dispatch.vector = cepu_pkg::VEC_PAGE;
                end else begin
                    next_dispatch.vector = seg_vector(next_rank == cepu_pkg::RANK_FETCH ?
                                                      events.fetch_kind : events.opnd_kind);
                end
            end
            cepu_pkg::RANK_DECODE: begin
                next_dispatch.vector = cepu_pkg::VEC_BAD_OPCODE;
            end
            cepu_pkg::RANK_WAIT_DNA, cepu_pkg::RANK_FOP_DNA: begin
                next_dispatch.vector = cepu_pkg::VEC_DEV_NA;
            end
            cepu_pkg::RANK_FPU_ERR: begin
                next_dispatch.vector = cepu_pkg::VEC_FPU_ERR;
            end
            cepu_pkg::RANK_PAGE_OPND: begin
                next_dispatch.vector = cepu_pkg::VEC_PAGE;
            end
            cepu_pkg::RANK_ALIGN: begin
                // A double fault aborts and outranks the alignment check it shares a slot with.
                next_dispatch.vector = events.double_fault ? cepu_pkg::VEC_DOUBLE : cepu_pkg::VEC_ALIGN;
            end
            default: begin
                next_dispatch.vector = 8'h00;
            end
        endcase
        // Error code selection by vector.
        unique case (next_dispatch.vector)
            cepu_pkg::VEC_DOUBLE, cepu_pkg::VEC_ALIGN: begin
                next_dispatch.push_error = prot;
                next_dispatch.error_code = cepu_pkg::EC_ZERO;
            end
            cepu_pkg::VEC_PAGE: begin
                next_dispatch.push_error = prot;
                next_dispatch.error_code = cepu_pkg::EC_ZERO;
                next_dispatch.error_code[cepu_pkg::EC_S2_BIT] = !events.page_not_present;
                next_dispatch.error_code[cepu_pkg::EC_S1_BIT] = events.page_write;
                next_dispatch.error_code[cepu_pkg::EC_S0_BIT] = events.page_user;
            end
            cepu_pkg::VEC_BAD_TASK, cepu_pkg::VEC_SEG_NP, cepu_pkg::VEC_STACK,
            cepu_pkg::VEC_GEN_PROT: begin
                next_dispatch.push_error = prot;
                next_dispatch.error_code = prot ? seg_code(events) : cepu_pkg::EC_ZERO;
            end
            default: begin
                next_dispatch.push_error = 1'b0;
                next_dispatch.error_code = cepu_pkg::EC_ZERO;
            end
        endcase
        // Vectors 8, 12 and 13 carry their limit overrun meanings outside protected mode.
        next_dispatch.real_mode_meaning = !prot && next_dispatch.valid &&
            (next_dispatch.vector == cepu_pkg::VEC_DOUBLE || next_dispatch.vector == cepu_pkg::VEC_STACK ||
             next_dispatch.vector == cepu_pkg::VEC_GEN_PROT);
        // A fault that switches into a partly absent task segment cannot be restarted.
        next_dispatch.restartable = !(task_switch_partial && next_dispatch.valid
                                      && next_rank >= cepu_pkg::RANK_FETCH);
        if (next_dispatch.vector == cepu_pkg::VEC_DOUBLE) begin
            next_dispatch.restartable = 1'b0;
        end
    end

    // Dispatch register.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dispatch <= '0;
        end else if (clk_en) begin
            dispatch <= next_dispatch;
        end
    end

    // Management request is edge sensitive, so the falling edge is latched until served.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            smi_prev <= 1'b1;
            smi_pend <= 1'b0;
        end else if (clk_en) begin
            smi_prev <= system_mgmt_irq_n;
            if (smi_prev && !system_mgmt_irq_n) begin
                smi_pend <= 1'b1;
            end else if (boundary && next_rank == cepu_pkg::RANK_SMI) begin
                smi_pend <= 1'b0;
            end
        end
    end

    // NMI is latched on its rising edge and held until it wins a boundary.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            nmi_prev <= 1'b0;
            nmi_pend <= 1'b0;
        end else if (clk_en) begin
            nmi_prev <= nmi_request;
            if (!nmi_prev && nmi_request) begin
                nmi_pend <= 1'b1;
            end else if (boundary && next_rank == cepu_pkg::RANK_NMI) begin
                nmi_pend <= 1'b0;
            end
        end
    end

    // Management mode flag; left by software writing the status word.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sys_mgmt_mode <= 1'b0;
        end else if (clk_en) begin
            if (boundary && next_rank == cepu_pkg::RANK_SMI) begin
                sys_mgmt_mode <= 1'b1;
            end else if (wb_hit && wb_we_i && wb_adr_i == cepu_pkg::ADDR_STATUS && wb_sel_i[0]
                         && wb_dat_i[0]) begin
                sys_mgmt_mode <= 1'b0;
            end
        end
    end

    // Control register.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl <= cepu_pkg::CTRL_RESET;
        end else if (clk_en && wb_hit && wb_we_i && wb_adr_i == cepu_pkg::ADDR_CTRL && wb_sel_i[0]) begin
            ctrl <= wb_dat_i[6:0];
        end
    end

    // Bus answer one cycle after the request; unmapped reads return zero.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (clk_en) begin
            wb_ack_o <= wb_hit;
            unique case (wb_adr_i)
                cepu_pkg::ADDR_CTRL:   wb_dat_o <= {25'h0000000, ctrl};
                cepu_pkg::ADDR_STATUS: wb_dat_o <= {16'h0000, first_set(req), 9'h000,
                                                    nmi_pend, smi_pend, sys_mgmt_mode};
                cepu_pkg::ADDR_RESULT: wb_dat_o <= {dispatch.rank, dispatch.vector, dispatch.error_code,
                                                    1'b0, dispatch.push_error, dispatch.restartable,
                                                    dispatch.valid};
                default:               wb_dat_o <= 32'h00000000;
            endcase
        end
    end

endmodule

// ---- verification/cepu_resolver_chk.sv ----
// Checker of dispatch and bus timing at the resolver ports.
`timescale 1ns/1ps
module cepu_resolver_chk (
    // Clock and reset.
    input wire logic                     sys_clk,
    input wire logic                     rst_n,
    input wire logic                     clk_en,
    // Requests and pipeline.
    input wire logic                     maskable_irq_request,
    input wire logic                     boundary,
    input wire logic                     task_switch_partial,
    // Results.
    input wire logic                     sys_mgmt_mode,
    input wire cepu_pkg::cepu_dispatch_t dispatch,
    // Bus.
    input wire logic                     wb_cyc_i,
    input wire logic                     wb_stb_i,
    input wire logic                     wb_ack_o
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_offer;
        boundary && clk_en;
    endsequence
    sequence s_mgmt_taken;
        dispatch.valid && dispatch.mgmt_entry;
    endsequence
    a_valid_cause: assert property (dispatch.valid && $past(clk_en) |-> $past(boundary))
        else $error("dispatch without a boundary");
    a_offer_answer: assert property (s_offer |=> dispatch.valid == (dispatch.rank != cepu_pkg::RANK_NONE))
        else $error("pending event not dispatched");
    a_mgmt_rank: assert property (dispatch.valid
        |-> dispatch.mgmt_entry == (dispatch.rank == cepu_pkg::RANK_SMI))
        else $error("management entry rank wrong");
    a_mgmt_mode_set: assert property (s_mgmt_taken |-> ##[0:1] sys_mgmt_mode)
        else $error("management mode not entered");
    a_nmi_vector: assert property (dispatch.valid && dispatch.rank == cepu_pkg::RANK_NMI
        |-> dispatch.vector == 8'h02)
        else $error("nmi vector wrong");
    a_mirq_level: assert property (dispatch.valid && dispatch.rank == cepu_pkg::RANK_MIRQ
        |-> $past(maskable_irq_request))
        else $error("maskable taken without request");
    a_zero_code: assert property (dispatch.valid && dispatch.push_error && (dispatch.vector == 8'h08
        || dispatch.vector == 8'h11) |-> dispatch.error_code == 16'h0000)
        else $error("nonzero code for double or alignment");
    a_fault_restart: assert property (dispatch.valid && dispatch.rank >= cepu_pkg::RANK_FETCH && !dispatch.restartable
        |-> $past(task_switch_partial) || dispatch.vector == 8'h08)
        else $error("fault not restartable");
    a_ack_pulse: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_reset_clear: assert property ($rose(rst_n) |-> dispatch == '0 && !sys_mgmt_mode)
        else $error("state survives reset");
endmodule

bind cepu_resolver cepu_resolver_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .maskable_irq_request(maskable_irq_request), .boundary(boundary), .task_switch_partial(task_switch_partial),
    .sys_mgmt_mode(sys_mgmt_mode), .dispatch(dispatch), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o));

// ---- verification/cepu_irq_src.sv ----
// Model of the interrupt controller and chipset driving the request pins.
`timescale 1ns/1ps
module cepu_irq_src (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Commands from the bench.
    input  wire logic smi_go,
    input  wire logic nmi_go,
    input  wire logic mirq_lvl,
    // Request pins.
    output logic      system_mgmt_irq_n,
    output logic      nmi_request,
    output logic      maskable_irq_request
);
    logic [1:0] smi_cnt;
    logic [1:0] nmi_cnt;
    // Each event makes a fresh edge; active three cycles so two samples see it.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            smi_cnt <= 2'h0;
            nmi_cnt <= 2'h0;
            maskable_irq_request <= 1'b0;
        end else begin
            smi_cnt <= smi_go ? 2'h3 : smi_cnt - 2'(smi_cnt != 2'h0);
            nmi_cnt <= nmi_go ? 2'h3 : nmi_cnt - 2'(nmi_cnt != 2'h0);
            maskable_irq_request <= mirq_lvl;
        end
    end
    assign system_mgmt_irq_n = (smi_cnt == 2'h0);
    assign nmi_request = (nmi_cnt != 2'h0);
endmodule

// ---- verification/cepu_resolver_tb.sv ----
// Self-checking bench for the resolver against a reference model.
`timescale 1ns/1ps
module cepu_resolver_tb;
    localparam logic [33:0] FLAGS = 34'h3CF918000;
    logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, boundary = 1'b0, task_switch_partial = 1'b0;
    logic smi_go = 1'b0, nmi_go = 1'b0, mirq_lvl = 1'b0;
    logic system_mgmt_irq_n, nmi_request, maskable_irq_request, sys_mgmt_mode, wb_ack_o;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [6:0] ctrl = 7'h00;
    cepu_pkg::cepu_events_t events = '0;
    cepu_pkg::cepu_dispatch_t dispatch;
    int n_mismatch = 0, n_tests = 0, cyc_cnt = 0;
    bit smi_p = 0, nmi_p = 0;

    cepu_irq_src u_src (.sys_clk(sys_clk), .rst_n(rst_n), .smi_go(smi_go), .nmi_go(nmi_go), .mirq_lvl(mirq_lvl),
        .system_mgmt_irq_n(system_mgmt_irq_n), .nmi_request(nmi_request),
        .maskable_irq_request(maskable_irq_request));
    cepu_resolver DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .system_mgmt_irq_n(system_mgmt_irq_n),
        .nmi_request(nmi_request), .maskable_irq_request(maskable_irq_request), .boundary(boundary),
        .events(events), .task_switch_partial(task_switch_partial), .sys_mgmt_mode(sys_mgmt_mode),
        .dispatch(dispatch), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

    always #2.5 sys_clk = ~sys_clk;

    task automatic complete_run();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // The run needs about four thousand cycles; the margin covers bus waits.
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 30000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 40);
        q = wb_dat_o;
        check("bus ack", 1, wb_ack_o);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask

    function automatic int seg_vec(logic [1:0] k, bit prot);
        if (!prot) return (k == 2'h1) ? 12 : 13;
        return (k == 2'h0) ? 11 : (k == 2'h1) ? 12 : (k == 2'h2) ? 13 : 10;
    endfunction

    function automatic int exp_rank(cepu_pkg::cepu_events_t e, bit mirq);
        if (smi_p) return 1;
        if (e.dbg_prev) return 2;
        if (e.dbg_next) return 3;
        if (nmi_p && ctrl[6]) return 4;
        if (mirq && ctrl[1]) return 5;
        if (e.fetch_fault || (e.fetch_page && ctrl[0])) return 6;
        if (e.decode_fault) return 7;
        if (e.is_wait && ctrl[2] && ctrl[3]) return 8;
        if (e.is_float_unit_opcode && (ctrl[4] || ctrl[2])) return 9;
        if (e.fpu_unmasked_err && ctrl[5]) return 10;
        if (e.opnd_seg_fault) return 11;
        if (e.opnd_page_fault && ctrl[0]) return 12;
        if (e.align_fault || e.double_fault) return 13;
        return 15;
    endfunction

    function automatic int exp_vec(int r, cepu_pkg::cepu_events_t e);
        case (r)
            1, 5: return 0;
            2, 3: return 1;
            4: return 2;
            6: return e.fetch_fault ? seg_vec(e.fetch_kind, ctrl[0]) : 14;
            7: return 6;
            8, 9: return 7;
            10: return 16;
            11: return seg_vec(e.opnd_kind, ctrl[0]);
            12: return 14;
            13: return e.double_fault ? 8 : 17;
            default: return -1;
        endcase
    endfunction

    function automatic logic [33:0] rnd34();
        return 34'({$urandom, $urandom});
    endfunction

    initial begin
        cepu_pkg::cepu_events_t ev;
        int r;
        int v;
        bit mirq, fs, fn, tsp, push;
        r = $urandom(35);
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        wb(1'b0, cepu_pkg::ADDR_CTRL, 32'h0, rd);
        check("ctrl reset", {25'h0, cepu_pkg::CTRL_RESET}, rd);
        wb(1'b1, 4'hC, 32'hFFFFFFFF, rd);
        wb(1'b0, 4'hC, 32'h0, rd);
        check("unmapped", 32'h0, rd);
        for (int i = 0; i < 400; i++) begin
            if (i % 8 == 0) begin
                ctrl = 7'($urandom);
                wb(1'b1, cepu_pkg::ADDR_CTRL, {25'h0, ctrl}, rd);
                wb(1'b0, cepu_pkg::ADDR_CTRL, 32'h0, rd);
                check("ctrl", {25'h0, ctrl}, rd);
            end
            mirq = 1'($urandom);
            fs = ($urandom % 5 == 0);
            fn = ($urandom % 4 == 0);
            smi_go <= fs;
            nmi_go <= fn;
            mirq_lvl <= mirq;
            @(posedge sys_clk);
            smi_go <= 1'b0;
            nmi_go <= 1'b0;
            clk_en <= 1'($urandom);
            @(posedge sys_clk);
            clk_en <= 1'b1;
            repeat (4) @(posedge sys_clk);
            smi_p |= fs;
            nmi_p |= fn;
            ev = cepu_pkg::cepu_events_t'(rnd34() & ~(FLAGS & ~(rnd34() & rnd34() & rnd34())));
            tsp = ($urandom % 16 == 0);
            boundary <= 1'b1;
            events <= ev;
            task_switch_partial <= tsp;
            @(posedge sys_clk);
            boundary <= 1'b0;
            #1;
            r = exp_rank(ev, mirq);
            v = exp_vec(r, ev);
            push = ctrl[0] && (v inside {8, 10, 11, 12, 13, 14, 17});
            check("valid", 32'(r != 15), dispatch.valid);
            if (r != 15) check("rank", r, dispatch.rank);
            if (v >= 0) check("vector", v, dispatch.vector);
            if (v >= 0) check("push", push, dispatch.push_error);
            if (push && (r == 6 || r == 11) && v != 14) check("code", {ev.sel_index, ev.sel_ti, 1'b0, ev.sel_ext},
                dispatch.error_code);
            if (push && v == 14) check("page code", {!ev.page_not_present, ev.page_write, ev.page_user},
                dispatch.error_code[2:0]);
            if (push && r == 13) check("zero code", 0, dispatch.error_code);
            if (r >= 6 && r != 15) check("restart", !(tsp || v == 8), dispatch.restartable);
            if (r != 15) check("real meaning", 32'(!ctrl[0] && (v inside {8, 12, 13})),
                dispatch.real_mode_meaning);
            if (r == 4) nmi_p = 0;
            @(posedge sys_clk);
            if (r == 1) begin
                smi_p = 0;
                check("mgmt mode", 1, sys_mgmt_mode);
                wb(1'b1, cepu_pkg::ADDR_STATUS, 32'h1, rd);
                wb(1'b0, cepu_pkg::ADDR_STATUS, 32'h0, rd);
                check("mgmt clear", 0, rd[0]);
            end
        end
        complete_run();
    end
endmodule
